// ===== design/fwsr_regs.vh
// constants for the flash write-status polling controller
`ifndef FWSR_REGS_VH
`define FWSR_REGS_VH
// status bit positions on the data bus
`define FWSR_BIT_POLL          7
`define FWSR_BIT_TOGGLE        6
`define FWSR_BIT_FAIL          5
`define FWSR_BIT_TIMER         3
`define FWSR_BIT_SECTOR        2
// operation kinds on the user port
`define FWSR_OP_PROGRAM        2'h0
`define FWSR_OP_SECTOR_ERASE   2'h1
`define FWSR_OP_CHIP_ERASE     2'h2
`define FWSR_OP_ADD_SECTOR     2'h3
// result codes
`define FWSR_RES_DONE          2'h0
`define FWSR_RES_FAIL          2'h1
`define FWSR_RES_TIMER_LATE    2'h2
// command bytes
`define FWSR_CMD_RESET         8'hF0
`define FWSR_CMD_SECTOR_ERASE  8'h30
// bus cycle timing in ns and in clocks
`define FWSR_CYCLE_NS          40
`define FWSR_CLK_NS            10
`define FWSR_CYCLE_CLKS        ((`FWSR_CYCLE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`endif

// ===== design/fwsr_bus_cycle.v
// single read or write cycle on the flash parallel pins
`timescale 1ns/1ps
module fwsr_bus_cycle #(
  parameter AW    = 20,
  parameter DW    = 8,
  parameter CLKS  = 4
) (
  input  wire          clock,
  input  wire          reset,
  input  wire          start,
  input  wire          write,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg           done_r,
  output reg  [DW-1:0] rdata_r,
  output reg           ce_n_r,
  output reg           oe_n_r,
  output reg           we_n_r,
  output reg  [AW-1:0] a_r,
  output reg  [DW-1:0] dq_out_r,
  output reg           dq_oe_r,
  input  wire [DW-1:0] dq_in
);
  reg [7:0] cnt_r;
  reg       busy_r;
  reg       wr_r;
  // -----------------------------
  // strobe sequencing
  // -----------------------------
  always @(posedge clock)
  begin
    done_r <= 1'b0;
    if (reset)
    begin
      busy_r   <= 1'b0;
      wr_r     <= 1'b0;
      cnt_r    <= 8'h00;
      ce_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      we_n_r   <= 1'b1;
      a_r      <= {AW{1'b0}};
      dq_out_r <= {DW{1'b0}};
      dq_oe_r  <= 1'b0;
      rdata_r  <= {DW{1'b0}};
    end
    else if (!busy_r)
    begin
      if (start)
      begin
        busy_r   <= 1'b1;
        wr_r     <= write;
        cnt_r    <= CLKS[7:0];
        a_r      <= addr;
        dq_out_r <= wdata;
        dq_oe_r  <= write;
        ce_n_r   <= 1'b0;
        oe_n_r   <= write;
        we_n_r   <= ~write;
      end
    end
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    else
    begin
      // rising strobe ends the cycle; read data latched here
      if (!wr_r)
        rdata_r <= dq_in;
      busy_r  <= 1'b0;
      ce_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      dq_oe_r <= 1'b0;
      done_r  <= 1'b1;
    end
  end
endmodule // fwsr_bus_cycle

// ===== design/fwsr_poller.v
// host-side status poller for an asynchronous nor flash
// Operation
// [R1] primary toggle readable at any address
// [R2] primary toggle inverts per read while busy
// [R3] all-protected erase toggles about 100 us
// [R4] partly protected erase skips protected sectors
// [R5] toggle stops when erase suspended
// [R6] protected program toggles about 1 us
// [R7] suspend-program toggles until program done
// [R8] sector toggle bit toggles in erase sectors
// [R9] sector toggle valid after final strobe
// [R10] combine both toggles for sector mode
// [R11] double read; unchanged toggle means done
// [R12] toggling plus fail flag: recheck, reset
// [R13] resumed polling restarts from double read
// [R14] fail flag high past pulse limit
// [R15] programming zero to one fails
// [R16] after failure issue reset command
// [R17] erase timer flag low during time-out
// [R18] timer high: only suspend accepted
// [R19] timer ignorable if commands under 50 us
// [R20] check timer before and after sector add
// [R21] supply valid address for sector toggle
// [R22] poll bit complement while programming
// [R23] poll bit zero during erase
// [R24] ready/busy low while busy
// [R25] idle array reads show no toggling
`timescale 1ns/1ps
`include "fwsr_regs.vh"
module fwsr_poller #(
  parameter AW = 20,
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          reset,
  input  wire          op_start,
  input  wire [1:0]    op_kind,
  input  wire [AW-1:0] op_addr,
  input  wire          op_abandon,
  output reg           op_busy_r,
  output reg           op_done_r,
  output reg  [1:0]    op_result_r,
  output reg           suspended_r,
  output reg           sector_erasing_r,
  output reg           ready_r,
  output reg  [DW-1:0] last_status_r,
  output wire          flash_ce_n,
  output wire          flash_oe_n,
  output wire          flash_we_n,
  output wire [AW-1:0] flash_addr,
  output wire [DW-1:0] flash_dq_out,
  output wire          flash_dq_oe,
  input  wire [DW-1:0] flash_dq_in,
  input  wire          ready_busy_n_output
);
  localparam S_IDLE   = 4'd0;
  localparam S_TMR0   = 4'd1;
  localparam S_ADD    = 4'd2;
  localparam S_TMR1   = 4'd3;
  localparam S_RD1    = 4'd4;
  localparam S_RD2    = 4'd5;
  localparam S_RD3    = 4'd6;
  localparam S_RESET  = 4'd7;
  localparam S_FINISH = 4'd8;

  reg  [3:0]    state_r;
  reg  [3:0]    state_nxt;
  reg  [AW-1:0] addr_r;
  reg  [1:0]    kind_r;
  reg  [DW-1:0] first_r;
  reg  [1:0]    res_r;
  reg           cyc_start;
  reg           cyc_write;
  reg  [DW-1:0] cyc_wdata;
  wire          cyc_done;
  wire [DW-1:0] cyc_rdata;
  wire [AW-1:0] cyc_addr;

  // first cycle of an operation starts on the same edge that loads addr_r
  assign cyc_addr = (state_r == S_IDLE) ? op_addr : addr_r;  // [R21]

  function toggled;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      toggled = a[`FWSR_BIT_TOGGLE] ^ b[`FWSR_BIT_TOGGLE];
    end
  endfunction

  fwsr_bus_cycle #(
    .AW   (AW),
    .DW   (DW),
    .CLKS (`FWSR_CYCLE_CLKS)
  ) u_cyc (
    .clock    (clock),
    .reset    (reset),
    .start    (cyc_start),
    .write    (cyc_write),
    .addr     (cyc_addr),
    .wdata    (cyc_wdata),
    .done_r   (cyc_done),
    .rdata_r  (cyc_rdata),
    .ce_n_r   (flash_ce_n),
    .oe_n_r   (flash_oe_n),
    .we_n_r   (flash_we_n),
    .a_r      (flash_addr),
    .dq_out_r (flash_dq_out),
    .dq_oe_r  (flash_dq_oe),
    .dq_in    (flash_dq_in)
  );

  // -----------------------------
  // next state and cycle launch
  // -----------------------------
  always @*
  begin
    state_nxt = state_r;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_wdata = {DW{1'b0}};
    case (state_r)
      S_IDLE:
        if (op_start)
        begin
          cyc_start = 1'b1;
          if (op_kind == `FWSR_OP_ADD_SECTOR)
            state_nxt = S_TMR0;                      // [R20]
          else
            state_nxt = S_RD1;                       // [R11]
        end
      S_TMR0:
        if (cyc_done)
        begin
          cyc_start = 1'b1;
          if (cyc_rdata[`FWSR_BIT_TIMER])            // [R18] [R19]
          begin
            state_nxt = S_RD1;
          end
          else
          begin
            cyc_write = 1'b1;
            cyc_wdata = `FWSR_CMD_SECTOR_ERASE;
            state_nxt = S_ADD;
          end
        end
      S_ADD:
        if (cyc_done)
        begin
          cyc_start = 1'b1;
          state_nxt = S_TMR1;                        // [R20]
        end
      S_TMR1:
        if (cyc_done)
        begin
          cyc_start = 1'b1;
          state_nxt = S_RD1;
        end
      S_RD1:
        if (op_abandon)
          state_nxt = S_FINISH;                      // [R13]
        else if (cyc_done)
        begin
          cyc_start = 1'b1;
          state_nxt = S_RD2;
        end
      S_RD2:
        if (cyc_done)
        begin
          if (!toggled(first_r, cyc_rdata))          // [R11]
            state_nxt = S_FINISH;
          else if (cyc_rdata[`FWSR_BIT_FAIL])        // [R12]
          begin
            cyc_start = 1'b1;
            state_nxt = S_RD3;
          end
          else
          begin
            cyc_start = 1'b1;
            state_nxt = S_RD2;                       // [R2]
          end
        end
      S_RD3:
        if (cyc_done)
        begin
          if (!toggled(first_r, cyc_rdata))          // [R12]
            state_nxt = S_FINISH;
          else
          begin
            cyc_start = 1'b1;
            cyc_write = 1'b1;
            cyc_wdata = `FWSR_CMD_RESET;             // [R16]
            state_nxt = S_RESET;
          end
        end
      S_RESET:
        if (cyc_done)
          state_nxt = S_FINISH;
      S_FINISH:
        state_nxt = S_IDLE;
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // -----------------------------
  // registers
  // -----------------------------
  always @(posedge clock)
  begin
    if (reset)
    begin
      state_r          <= S_IDLE;
      addr_r           <= {AW{1'b0}};
      kind_r           <= 2'h0;
      first_r          <= {DW{1'b0}};
      res_r            <= `FWSR_RES_DONE;
      op_busy_r        <= 1'b0;
      op_done_r        <= 1'b0;
      op_result_r      <= `FWSR_RES_DONE;
      suspended_r      <= 1'b0;
      sector_erasing_r <= 1'b0;
      ready_r          <= 1'b0;
      last_status_r    <= {DW{1'b0}};
    end
    else
    begin
      state_r   <= state_nxt;
      op_done_r <= 1'b0;
      ready_r   <= ready_busy_n_output;              // [R24]
      if (state_r == S_IDLE && op_start)
      begin
        addr_r    <= op_addr;                        // [R21]
        kind_r    <= op_kind;
        res_r     <= `FWSR_RES_DONE;
        op_busy_r <= 1'b1;
      end
      if (cyc_done)
        last_status_r <= cyc_rdata;
      if (state_r == S_TMR1 && cyc_done && cyc_rdata[`FWSR_BIT_TIMER])
        res_r <= `FWSR_RES_TIMER_LATE;               // [R20]
      if (state_r == S_TMR0 && cyc_done && cyc_rdata[`FWSR_BIT_TIMER])
        res_r <= `FWSR_RES_TIMER_LATE;               // [R18]
      if ((state_r == S_RD1 || state_r == S_RD2) && cyc_done)
        first_r <= cyc_rdata;
      if (state_r == S_RD2 && cyc_done)
      begin
        // primary toggle plus sector toggle pair     [R10]
        suspended_r      <= ~toggled(first_r, cyc_rdata) & (first_r[`FWSR_BIT_SECTOR] ^ cyc_rdata[`FWSR_BIT_SECTOR]);
        sector_erasing_r <= toggled(first_r, cyc_rdata) & (first_r[`FWSR_BIT_SECTOR] ^ cyc_rdata[`FWSR_BIT_SECTOR]);
      end
      if (state_r == S_RD3 && cyc_done && toggled(first_r, cyc_rdata))
        res_r <= `FWSR_RES_FAIL;                     // [R12]
      if (state_r == S_FINISH)
      begin
        op_busy_r   <= 1'b0;
        op_done_r   <= ~op_abandon | (res_r != `FWSR_RES_DONE);
        op_result_r <= res_r;
      end
    end
  end
endmodule // fwsr_poller

// ===== verification/fwsr_chk.sv
// port checks for the flash status poller
`timescale 1ns/1ps
`include "fwsr_regs.vh"
module fwsr_chk #(
  parameter AW = 20,
  parameter DW = 8
) (
  input wire          clock,
  input wire          reset,
  input wire          op_start,
  input wire [AW-1:0] op_addr,
  input wire          op_busy_r,
  input wire          op_done_r,
  input wire [1:0]    op_result_r,
  input wire          flash_oe_n,
  input wire          flash_we_n,
  input wire [AW-1:0] flash_addr,
  input wire [DW-1:0] flash_dq_out,
  input wire          flash_dq_oe
);
  reg [AW-1:0] exp_addr_r;
  // address taken with the accepted start
  always @(posedge clock)
    if (op_start && !op_busy_r)
      exp_addr_r <= op_addr;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_done_pulse:
    assert property (op_done_r |=> !op_done_r) else $error("done held");
  a_start_busy:
    assert property (op_start && !op_busy_r |=> op_busy_r) else $error("start not taken");
  a_two_reads:
    assert property (op_start && !op_busy_r |=> !op_done_r [*8]) else $error("done too early");
  a_read_len:
    assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 flash_oe_n) else $error("read length");
  a_idle_quiet:
    assert property (!op_busy_r |-> flash_oe_n && flash_we_n && !flash_dq_oe) else $error("idle strobe");
  a_write_cmd:
    assert property (!flash_we_n |-> flash_dq_oe && (flash_dq_out == `FWSR_CMD_RESET
      || flash_dq_out == `FWSR_CMD_SECTOR_ERASE)) else $error("bad write");
  a_addr_hold:
    assert property (!flash_oe_n && $past(!flash_oe_n) |-> $stable(flash_addr)) else $error("addr moved");
  a_addr_valid:
    assert property (!flash_oe_n |-> flash_addr == exp_addr_r) else $error("read at wrong address");
  a_result_hold:
    assert property (!op_done_r |-> $stable(op_result_r)) else $error("result moved");
  c_done: cover property (op_done_r && op_result_r == `FWSR_RES_DONE);
  c_fail: cover property (op_done_r && op_result_r == `FWSR_RES_FAIL);
  c_late: cover property (op_done_r && op_result_r == `FWSR_RES_TIMER_LATE);
endmodule // fwsr_chk
bind fwsr_poller fwsr_chk #(.AW(AW), .DW(DW)) u_fwsr_chk (.clock(clock), .reset(reset), .op_start(op_start),
  .op_addr(op_addr),
  .op_busy_r(op_busy_r), .op_done_r(op_done_r), .op_result_r(op_result_r), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));

// ===== verification/fwsr_flash_model.sv
// behavioural flash answering status reads
`timescale 1ns/1ps
module fwsr_flash_model (
  input  wire       clock,
  input  wire       load,
  input  wire [7:0] busy_reads,
  input  wire       fail_in,
  input  wire       timer_in,
  input  wire       suspend_in,
  input  wire       flash_ce_n,
  input  wire       flash_oe_n,
  input  wire       flash_we_n,
  input  wire [7:0] flash_dq_out,
  input  wire       flash_dq_oe,
  output wire [7:0] flash_dq_in,
  output wire       ready_busy_n_output
);
  reg  [7:0] left_r;
  reg        tog_r;
  reg        fail_r;
  reg        rd_d_r;
  wire       rd   = !flash_ce_n && !flash_oe_n;
  wire       busy = left_r != 8'h00;
  wire [7:0] stat = (busy || fail_r) ? {1'b0, tog_r & ~suspend_in, fail_r, 1'b0, timer_in, tog_r, 2'h0}
                                     : 8'hA5;
  // released bus never shows the last byte
  assign flash_dq_in = rd ? stat : ~stat;
  assign ready_busy_n_output = !busy || suspend_in;
  always @(posedge clock)
  begin
    rd_d_r <= rd;
    if (load)
    begin
      left_r <= busy_reads;
      fail_r <= fail_in;
      tog_r  <= 1'b0;
    end
    else if (!flash_we_n && flash_dq_oe && flash_dq_out == 8'hF0)
    begin
      left_r <= 8'h00;
      fail_r <= 1'b0;
    end
    else if (rd_d_r && !rd && busy)
    begin
      tog_r  <= ~tog_r;
      left_r <= left_r - 8'h01;
    end
  end
endmodule // fwsr_flash_model

// ===== verification/tb_top.sv
// self-checking bench for the flash status poller
`timescale 1ns/1ps
`include "fwsr_regs.vh"
module tb_top;
  reg        clock = 1'b0;
  reg        reset = 1'b1;
  reg        op_start = 1'b0;
  reg  [1:0] op_kind = 2'h0;
  reg        load = 1'b1;
  reg  [7:0] busy_reads = 8'h00;
  reg        fail_in = 1'b0;
  reg        timer_in = 1'b0;
  reg        suspend_in = 1'b0;
  integer    miscompares = 0;
  integer    comparisons = 0;
  wire       busy, done, ready, ce_n, oe_n, we_n, dq_oe, rb_n, susp, sect;
  wire [1:0] result;
  wire [19:0] addr;
  wire [7:0] dq_out, dq_in, status;
  always #5 clock = ~clock;
  fwsr_poller u_fwsr_poller (.clock(clock), .reset(reset), .op_start(op_start), .op_kind(op_kind),
    .op_addr(20'h0_1234), .op_abandon(1'b0), .op_busy_r(busy), .op_done_r(done), .op_result_r(result),
    .suspended_r(susp), .sector_erasing_r(sect), .ready_r(ready), .last_status_r(status), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in), .ready_busy_n_output(rb_n));
  fwsr_flash_model u_fwsr_flash_model (.clock(clock), .load(load), .busy_reads(busy_reads), .fail_in(fail_in),
    .timer_in(timer_in), .suspend_in(suspend_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .ready_busy_n_output(rb_n));
  task complete_run;
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task check(input [7:0] seen, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task run_op(input [1:0] kind, input [7:0] n, input f, input t);
    integer i;
  begin
    @(negedge clock);
    load = 1'b1;
    busy_reads = n;
    fail_in = f;
    timer_in = t;
    @(negedge clock);
    load = 1'b0;
    op_kind = kind;
    op_start = 1'b1;
    @(negedge clock);
    op_start = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 3000)
    begin
      @(negedge clock);
      i = i + 1;
    end
    if (i == 3000)
    begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end
  endtask
  task t_kinds;
    integer k;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      run_op(k[1:0], 8'h06, 1'b0, 1'b0);
      check({6'h00, result}, {6'h00, `FWSR_RES_DONE});
      check({7'h00, ready}, 8'h01);
      check({7'h00, susp}, 8'h00);
      check({7'h00, sect}, 8'h00);
    end
    $display("test kinds finished");
  end
  endtask
  task t_idle;
  begin
    run_op(2'h0, 8'h00, 1'b0, 1'b0);
    check({6'h00, result}, {6'h00, `FWSR_RES_DONE});
    check(status, 8'hA5);
    $display("test idle finished");
  end
  endtask
  task t_fail;
  begin
    run_op(2'h0, 8'hFF, 1'b1, 1'b0);
    check({6'h00, result}, {6'h00, `FWSR_RES_FAIL});
    repeat (2) @(negedge clock);
    check({7'h00, ready}, 8'h01);
    $display("test fail finished");
  end
  endtask
  task t_timer;
  begin
    run_op(2'h3, 8'h06, 1'b0, 1'b1);
    check({6'h00, result}, {6'h00, `FWSR_RES_TIMER_LATE});
    $display("test timer finished");
  end
  endtask
  task t_suspend;
  begin
    suspend_in = 1'b1;
    run_op(2'h1, 8'h06, 1'b0, 1'b0);
    check({6'h00, result}, {6'h00, `FWSR_RES_DONE});
    check({7'h00, susp}, 8'h01);
    check({7'h00, sect}, 8'h00);
    check({7'h00, ready}, 8'h01);
    suspend_in = 1'b0;
    $display("test suspend finished");
  end
  endtask
  initial
  begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    load = 1'b0;
    t_kinds;
    t_idle;
    t_fail;
    t_timer;
    t_suspend;
    complete_run;
  end
endmodule // tb_top
